// [iopd_core.sv]
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module iopd_core
  import iopd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire iopd_core_s core_i,
  output iopd_resp_s resp_o,
  input wire logic [4*NIB_W-1:0] port_in_i,
  input wire logic [PD_W-1:0] port_d_i,
  output logic [4*NIB_W-1:0] port_out_o,
  output logic [PD_W-1:0] port_d_o,
  output logic port_c_o,
  output logic [4*NIB_W-1:0] drive_type_o,
  output logic [4*NIB_W-1:0] pullup_o,
  output logic [4*NIB_W-1:0] wakeup_o,
  output logic [3*NIB_W-1:0] lcd_ctrl_o,
  output logic [3*NIB_W-1:0] lcd_config_o,
  output logic [NIB_W-1:0] clock_mode_o,
  output logic [NIB_W-1:0] clock_gate_o,
  input wire iopd_bus_s bus_i,
  output logic [BDATA_W-1:0] bus_rdata_o
);

  // ----------------------------------------------------------------
  // Opcode table
  // ----------------------------------------------------------------
  function automatic iopd_dec_s decode(input iopd_op_t op);
    iopd_dec_s d;
    d = '0;
    if ((op & OP_PORT_SEL_MASK) == OP_READ_PORT) begin
      d = '{1'b1, 1'b1, 1'b0, IDX_PORT0 + iopd_idx_t'(op[1:0])};
    end else if ((op & OP_PORT_SEL_MASK) == OP_WRITE_PORT) begin
      d = '{1'b0, 1'b0, 1'b1, IDX_PORT0 + iopd_idx_t'(op[1:0])};
    end else begin
      case (op)
        10'h228: d = '{1'b0, 1'b0, 1'b1, IDX_DRV0};
        10'h229: d = '{1'b0, 1'b0, 1'b1, IDX_DRV0 + 5'h01};
        10'h22A: d = '{1'b0, 1'b0, 1'b1, IDX_DRV0 + 5'h02};
        10'h22B: d = '{1'b0, 1'b0, 1'b1, IDX_DRV0 + 5'h03};
        10'h257: d = '{1'b1, 1'b0, 1'b0, IDX_PUP0};
        10'h22D: d = '{1'b0, 1'b0, 1'b1, IDX_PUP0};
        10'h25E: d = '{1'b1, 1'b0, 1'b0, IDX_PUP0 + 5'h01};
        10'h22E: d = '{1'b0, 1'b0, 1'b1, IDX_PUP0 + 5'h01};
        10'h25F: d = '{1'b1, 1'b0, 1'b0, IDX_PUP0 + 5'h02};
        10'h22F: d = '{1'b0, 1'b0, 1'b1, IDX_PUP0 + 5'h02};
        10'h25D: d = '{1'b1, 1'b0, 1'b0, IDX_PUP0 + 5'h03};
        10'h208: d = '{1'b0, 1'b0, 1'b1, IDX_PUP0 + 5'h03};
        10'h256: d = '{1'b1, 1'b0, 1'b0, IDX_WAKE0};
        10'h259: d = '{1'b1, 1'b0, 1'b0, IDX_WAKE0 + 5'h01};
        10'h25A: d = '{1'b1, 1'b0, 1'b0, IDX_WAKE0 + 5'h02};
        10'h25B: d = '{1'b1, 1'b0, 1'b0, IDX_WAKE0 + 5'h03};
        10'h21B: d = '{1'b0, 1'b0, 1'b1, IDX_WAKE0};
        10'h214: d = '{1'b0, 1'b0, 1'b1, IDX_WAKE0 + 5'h01};
        10'h215: d = '{1'b0, 1'b0, 1'b1, IDX_WAKE0 + 5'h02};
        10'h22C: d = '{1'b0, 1'b0, 1'b1, IDX_WAKE0 + 5'h03};
        10'h24A: d = '{1'b1, 1'b0, 1'b0, IDX_LCD1};
        10'h20A: d = '{1'b0, 1'b0, 1'b1, IDX_LCD1};
        10'h20B: d = '{1'b0, 1'b0, 1'b1, IDX_LCD1 + 5'h01};
        10'h20C: d = '{1'b0, 1'b0, 1'b1, IDX_LCD1 + 5'h02};
        10'h2A8: d = '{1'b0, 1'b0, 1'b1, IDX_CFG1};
        10'h2A9: d = '{1'b0, 1'b0, 1'b1, IDX_CFG1 + 5'h01};
        10'h226: d = '{1'b0, 1'b0, 1'b1, IDX_CFG1 + 5'h02};
        10'h252: d = '{1'b1, 1'b0, 1'b0, IDX_MODE};
        10'h216: d = '{1'b0, 1'b0, 1'b1, IDX_MODE};
        10'h209: d = '{1'b0, 1'b0, 1'b1, IDX_GATE};
        default: d = '0;
      endcase
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  iopd_state_e state_q, state_d;
  iopd_nib_t regs_q [NREG];
  logic [PD_W-1:0] pd_q, pd_d;
  logic pc_q, pc_d;
  iopd_resp_s resp_q, resp_d;
  logic [BDATA_W-1:0] rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // The tail word of the bit test is consumed, never decoded as an opcode
  wire in_tail = (state_q == ST_TEST_TAIL);
  wire live = core_i.valid && !in_tail;
  wire iopd_dec_s dec = decode(core_i.op);
  wire inst_we = live && dec.wr_en;
  wire inst_rd = live && dec.rd_en;
  wire op_all_set = live && (core_i.op == OP_PD_ALL_SET);
  wire op_bit_clr = live && (core_i.op == OP_PD_BIT_CLR);
  wire op_bit_set = live && (core_i.op == OP_PD_BIT_SET);
  wire op_test = live && (core_i.op == OP_PD_TEST);
  wire op_pc_clr = live && (core_i.op == OP_PC_CLR);
  wire op_pc_set = live && (core_i.op == OP_PC_SET);

  // Y beyond the port width selects no bit at all
  wire [PD_W-1:0] y_mask = core_i.y[3] ? PD_RST : (PD_ONE << core_i.y[2:0]);
  wire y_in_test_range = (core_i.y <= TEST_Y_MAX);
  wire pd_pin_bit = |(port_d_i & y_mask);

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire [ADDR_W-ADDR_IDX_LSB-1:0] bus_word = bus_i.addr[ADDR_W-1:ADDR_IDX_LSB];
  wire bus_aligned = (bus_i.addr[ADDR_IDX_LSB-1:0] == '0);
  wire bus_in_range = (bus_word <= (ADDR_W-ADDR_IDX_LSB)'(IDX_PORTC));
  wire iopd_idx_t bus_idx = bus_word[IDX_W-1:0];
  wire bus_hit = bus_aligned && bus_in_range;
  wire bus_we_arr = bus_i.wr && bus_hit && (bus_idx < iopd_idx_t'(NREG));
  wire bus_we_pd = bus_i.wr && bus_hit && (bus_idx == IDX_PORTD);
  wire bus_we_pc = bus_i.wr && bus_hit && (bus_idx == IDX_PORTC);

  // ----------------------------------------------------------------
  // Next-value selection
  // ----------------------------------------------------------------
  // Instruction writes take priority over a same-cycle register port write
  wire arr_we = inst_we || bus_we_arr;
  wire iopd_idx_t arr_idx = inst_we ? dec.idx : bus_idx;
  wire iopd_nib_t arr_raw = inst_we ? core_i.acc : bus_i.wdata[NIB_W-1:0];
  wire iopd_nib_t arr_val = (arr_idx == IDX_GATE) ? (arr_raw & GATE_MASK) : arr_raw;

  always_comb begin
    pd_d = pd_q;
    if (op_all_set) begin
      pd_d = PD_ALL;
    end else if (op_bit_clr) begin
      pd_d = pd_q & ~y_mask;
    end else if (op_bit_set) begin
      pd_d = pd_q | y_mask;
    end else if (bus_we_pd) begin
      pd_d = bus_i.wdata;
    end
  end

  always_comb begin
    pc_d = pc_q;
    if (op_pc_clr) begin
      pc_d = 1'b0;
    end else if (op_pc_set) begin
      pc_d = 1'b1;
    end else if (bus_we_pc) begin
      pc_d = bus_i.wdata[0];
    end
  end

  always_comb begin
    state_d = state_q;
    if (op_test) begin
      state_d = ST_TEST_TAIL;
    end else if (in_tail && core_i.valid) begin
      state_d = ST_IDLE;
    end
  end

  // Port reads sample the pins, the rest read the stored register
  wire iopd_nib_t pin_nib = port_in_i[dec.idx[1:0]*NIB_W +: NIB_W];
  always_comb begin
    resp_d.acc_we = inst_rd;
    resp_d.acc = dec.rd_pin ? pin_nib : regs_q[dec.idx];
    // A skip comes only from the bit test's second word
    resp_d.skip = in_tail && core_i.valid && y_in_test_range && !pd_pin_bit;
  end

  always_comb begin
    rdata_d = '0;
    if (bus_i.rd && bus_hit) begin
      if (bus_idx == IDX_PORTD) begin
        rdata_d = pd_q;
      end else if (bus_idx == IDX_PORTC) begin
        rdata_d = BDATA_W'(pc_q);
      end else begin
        rdata_d = BDATA_W'(regs_q[bus_idx]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= NIB_RST;
      end
    end else if (arr_we) begin
      regs_q[arr_idx] <= arr_val;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      pd_q <= PD_RST;
      pc_q <= 1'b0;
      resp_q <= '0;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      pd_q <= pd_d;
      pc_q <= pc_d;
      resp_q <= resp_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign resp_o = resp_q;
  assign bus_rdata_o = rdata_q;
  assign port_d_o = pd_q;
  assign port_c_o = pc_q;
  assign clock_mode_o = regs_q[IDX_MODE];
  assign clock_gate_o = regs_q[IDX_GATE];

  for (genvar g = 0; g < 4; g++) begin : g_quad
    assign port_out_o[g*NIB_W +: NIB_W] = regs_q[IDX_PORT0 + g];
    assign drive_type_o[g*NIB_W +: NIB_W] = regs_q[IDX_DRV0 + g];
    assign pullup_o[g*NIB_W +: NIB_W] = regs_q[IDX_PUP0 + g];
    assign wakeup_o[g*NIB_W +: NIB_W] = regs_q[IDX_WAKE0 + g];
  end

  for (genvar g = 0; g < 3; g++) begin : g_tri
    assign lcd_ctrl_o[g*NIB_W +: NIB_W] = regs_q[IDX_LCD1 + g];
    assign lcd_config_o[g*NIB_W +: NIB_W] = regs_q[IDX_CFG1 + g];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_port_read;
    @(posedge clk_i) disable iff (rst_i)
    (live && (core_i.op & OP_PORT_SEL_MASK) == OP_READ_PORT)
      |=> resp_o.acc_we && resp_o.acc == $past(pin_nib);
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read result wrong");

  property p_port_write;
    @(posedge clk_i) disable iff (rst_i)
    (live && core_i.op == OP_WRITE_PORT) |=> port_out_o[NIB_W-1:0] == $past(core_i.acc);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port zero latch not loaded");

  property p_bit_clr;
    @(posedge clk_i) disable iff (rst_i)
    op_bit_clr |=> port_d_o == ($past(pd_q) & ~$past(y_mask));
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("port D bit clear wrong");

  property p_bit_set;
    @(posedge clk_i) disable iff (rst_i)
    op_bit_set |=> port_d_o == ($past(pd_q) | $past(y_mask));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("port D bit set wrong");

  property p_test_skip;
    @(posedge clk_i) disable iff (rst_i)
    (op_test ##1 (core_i.valid && core_i.y <= TEST_Y_MAX))
      |=> resp_o.skip == !$past(pd_pin_bit);
  endproperty
  a_test_skip: assert property (p_test_skip) else $error("bit test skip wrong");

  property p_port_c;
    @(posedge clk_i) disable iff (rst_i)
    (op_pc_set || op_pc_clr) |=> port_c_o == $past(op_pc_set);
  endproperty
  a_port_c: assert property (p_port_c) else $error("port C not set");

  property p_gate_mask;
    @(posedge clk_i) disable iff (rst_i)
    (live && core_i.op == 10'h209) |=> clock_gate_o == ($past(core_i.acc) & GATE_MASK);
  endproperty
  a_gate_mask: assert property (p_gate_mask) else $error("clock gate load wrong");

  property p_one_cycle_read;
    @(posedge clk_i) disable iff (rst_i)
    (live && core_i.op == 10'h252) |=> resp_o.acc_we ##1 !resp_o.acc_we || $past(inst_rd);
  endproperty
  a_one_cycle_read: assert property (p_one_cycle_read) else $error("mode read slow");

  property p_no_stray_skip;
    @(posedge clk_i) disable iff (rst_i)
    resp_o.skip |-> $past(in_tail) && $past(core_i.valid) && $past(y_in_test_range);
  endproperty
  a_no_stray_skip: assert property (p_no_stray_skip) else $error("stray skip");

  property p_all_set;
    @(posedge clk_i) disable iff (rst_i)
    op_all_set |=> port_d_o == PD_ALL;
  endproperty
  a_all_set: assert property (p_all_set) else $error("port D not all set");

  property p_drive_write;
    @(posedge clk_i) disable iff (rst_i)
    (live && core_i.op == 10'h228) |=> drive_type_o[NIB_W-1:0] == $past(core_i.acc);
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("drive type not loaded");

  property p_pullup_read;
    @(posedge clk_i) disable iff (rst_i)
    (live && core_i.op == 10'h25D)
      |=> resp_o.acc_we && resp_o.acc == $past(pullup_o[4*NIB_W-1:3*NIB_W]);
  endproperty
  a_pullup_read: assert property (p_pullup_read) else $error("pull-up read wrong");

  property p_wake_read;
    @(posedge clk_i) disable iff (rst_i)
    (live && core_i.op == 10'h25B)
      |=> resp_o.acc_we && resp_o.acc == $past(wakeup_o[4*NIB_W-1:3*NIB_W]);
  endproperty
  a_wake_read: assert property (p_wake_read) else $error("wakeup read wrong");

  property p_wake_write;
    @(posedge clk_i) disable iff (rst_i)
    (live && core_i.op == 10'h22C) |=> wakeup_o[4*NIB_W-1:3*NIB_W] == $past(core_i.acc);
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("wakeup latch not loaded");

  property p_cfg_write;
    @(posedge clk_i) disable iff (rst_i)
    (live && core_i.op == 10'h226) |=> lcd_config_o[3*NIB_W-1:2*NIB_W] == $past(core_i.acc);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("LCD config not loaded");

  property p_tail_consumed;
    @(posedge clk_i) disable iff (rst_i)
    (in_tail && core_i.valid) |=> !resp_o.acc_we && !in_tail;
  endproperty
  a_tail_consumed: assert property (p_tail_consumed) else $error("bit test tail decoded");

endmodule

// [iopd_pkg.sv]
package iopd_pkg;

  // ----------------------------------------------------------------
  // Widths and storage
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int OP_W = 10;
  localparam int PD_W = 8;
  localparam int IDX_W = 5;
  localparam int ADDR_W = 8;
  localparam int BDATA_W = 8;
  localparam int NREG = 24;

  typedef logic [NIB_W-1:0] iopd_nib_t;
  typedef logic [OP_W-1:0] iopd_op_t;
  typedef logic [IDX_W-1:0] iopd_idx_t;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam iopd_idx_t IDX_PORT0 = 5'h00;
  localparam iopd_idx_t IDX_DRV0 = 5'h04;
  localparam iopd_idx_t IDX_PUP0 = 5'h08;
  localparam iopd_idx_t IDX_WAKE0 = 5'h0C;
  localparam iopd_idx_t IDX_LCD1 = 5'h10;
  localparam iopd_idx_t IDX_CFG1 = 5'h13;
  localparam iopd_idx_t IDX_MODE = 5'h16;
  localparam iopd_idx_t IDX_GATE = 5'h17;
  localparam iopd_idx_t IDX_PORTD = 5'h18;
  localparam iopd_idx_t IDX_PORTC = 5'h19;
  localparam int ADDR_IDX_LSB = 2;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam iopd_op_t OP_PORT_SEL_MASK = 10'h3FC;
  localparam iopd_op_t OP_READ_PORT = 10'h260;
  localparam iopd_op_t OP_WRITE_PORT = 10'h220;
  localparam iopd_op_t OP_PD_ALL_SET = 10'h011;
  localparam iopd_op_t OP_PD_BIT_CLR = 10'h014;
  localparam iopd_op_t OP_PD_BIT_SET = 10'h015;
  localparam iopd_op_t OP_PD_TEST = 10'h024;
  localparam iopd_op_t OP_PC_CLR = 10'h28C;
  localparam iopd_op_t OP_PC_SET = 10'h28D;

  // ----------------------------------------------------------------
  // Reset values, masks and limits
  // ----------------------------------------------------------------
  localparam iopd_nib_t NIB_RST = 4'h0;
  localparam iopd_nib_t GATE_MASK = 4'h7;
  localparam iopd_nib_t TEST_Y_MAX = 4'h4;
  localparam logic [PD_W-1:0] PD_RST = 8'h00;
  localparam logic [PD_W-1:0] PD_ALL = 8'hFF;
  localparam logic [PD_W-1:0] PD_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_TEST_TAIL} iopd_state_e;

  typedef struct packed {
    logic rd_en;
    logic rd_pin;
    logic wr_en;
    iopd_idx_t idx;
  } iopd_dec_s;

  typedef struct packed {
    logic valid;
    iopd_op_t op;
    iopd_nib_t acc;
    iopd_nib_t y;
  } iopd_core_s;

  typedef struct packed {
    logic acc_we;
    iopd_nib_t acc;
    logic skip;
  } iopd_resp_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [BDATA_W-1:0] wdata;
  } iopd_bus_s;

endpackage

// [iopd_pins_model.sv]
`timescale 1ns/1ps
module iopd_pins_model
  import iopd_pkg::*;
(
  input wire logic [4*NIB_W-1:0] ext_lvl_i,
  input wire logic [PD_W-1:0] sink_i,
  input wire logic [PD_W-1:0] latch_d_i,
  output logic [4*NIB_W-1:0] port_in_o,
  output logic [PD_W-1:0] port_d_o
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Input ports follow the outside world
  assign port_in_o = ext_lvl_i;
  // Port D open drain: an outside sink pulls a high latch bit low
  assign port_d_o = latch_d_i & ~sink_i;
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  import iopd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  iopd_core_s core_i = '0;
  iopd_bus_s bus_i = '0;
  iopd_resp_s resp_o;
  logic [4*NIB_W-1:0] ext_lvl = 16'h0000;
  logic [4*NIB_W-1:0] port_in_i, port_out_o, drive_type_o, pullup_o, wakeup_o;
  logic [PD_W-1:0] sink = 8'h00;
  logic [PD_W-1:0] port_d_i, port_d_o;
  logic port_c_o;
  logic [3*NIB_W-1:0] lcd_ctrl_o, lcd_config_o;
  logic [NIB_W-1:0] clock_mode_o, clock_gate_o;
  logic [BDATA_W-1:0] bus_rdata_o;
  logic [95:0] nibs;
  int errors = 0;
  int checks = 0;
  int r[26];
  int pend = 0;
  logic [31:0] seed = 32'h00006EAC;
  // ----------------------------------------------------------------
  // Opcode table: 0..23 writes to register i, 24..33 reads, rest misc
  // ----------------------------------------------------------------
  logic [9:0] all_op[45] = '{10'h220, 10'h221, 10'h222, 10'h223, 10'h228, 10'h229, 10'h22A,
    10'h22B, 10'h22D, 10'h22E, 10'h22F, 10'h208, 10'h21B, 10'h214, 10'h215, 10'h22C, 10'h20A,
    10'h20B, 10'h20C, 10'h2A8, 10'h2A9, 10'h226, 10'h216, 10'h209, 10'h257, 10'h25E, 10'h25F,
    10'h25D, 10'h256, 10'h259, 10'h25A, 10'h25B, 10'h24A, 10'h252, 10'h260, 10'h261, 10'h262,
    10'h263, 10'h011, 10'h014, 10'h015, 10'h024, 10'h28C, 10'h28D, 10'h3FF};
  int rd_idx[10] = '{8, 9, 10, 11, 12, 13, 14, 15, 16, 22};

  assign nibs = {clock_gate_o, clock_mode_o, lcd_config_o, lcd_ctrl_o, wakeup_o, pullup_o,
    drive_type_o, port_out_o};

  iopd_core dut (.clk_i(clk_i), .rst_i(rst_i), .core_i(core_i), .resp_o(resp_o),
    .port_in_i(port_in_i), .port_d_i(port_d_i), .port_out_o(port_out_o), .port_d_o(port_d_o),
    .port_c_o(port_c_o), .drive_type_o(drive_type_o), .pullup_o(pullup_o),
    .wakeup_o(wakeup_o), .lcd_ctrl_o(lcd_ctrl_o), .lcd_config_o(lcd_config_o),
    .clock_mode_o(clock_mode_o), .clock_gate_o(clock_gate_o), .bus_i(bus_i),
    .bus_rdata_o(bus_rdata_o));

  iopd_pins_model pins (.ext_lvl_i(ext_lvl), .sink_i(sink), .latch_d_i(port_d_o),
    .port_in_o(port_in_i), .port_d_o(port_d_i));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ----------------------------------------------------------------
  // Reference model, compared after every edge
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin : model
    int a, y, n_we, n_acc, n_skip, n_rd, idx;
    logic [9:0] op;
    op = core_i.op;
    a = core_i.acc;
    y = core_i.y;
    idx = bus_i.addr[7:2];
    n_we = 0;
    n_acc = 0;
    n_skip = 0;
    n_rd = 0;
    if (rst_i) begin
      foreach (r[i]) r[i] = 0;
      pend = 0;
    end else begin
      // Misaligned or unmapped places read zero and ignore writes
      if (bus_i.rd && bus_i.addr[1:0] == 2'h0 && idx < 26) n_rd = r[idx];
      if (bus_i.wr && bus_i.addr[1:0] == 2'h0 && idx < 26) begin
        r[idx] = bus_i.wdata & (idx == 24 ? 8'hFF : idx == 25 ? 8'h01 : idx == 23 ? 8'h07 : 8'h0F);
      end
      if (core_i.valid && pend) begin
        n_skip = (y <= 4) ? !port_d_i[y] : 0;
        pend = 0;
      end else if (core_i.valid) begin
        for (int i = 0; i < 34; i++) begin
          if (op == all_op[i] && i < 24) r[i] = (i == 23) ? (a & 7) : a;
          if (op == all_op[i] && i >= 24) begin
            n_we = 1;
            n_acc = r[rd_idx[i-24]];
          end
        end
        if (op[9:2] == 8'h98) begin
          n_we = 1;
          n_acc = port_in_i[op[1:0]*4 +: 4];
        end
        case (op)
          10'h011: r[24] = 8'hFF;
          10'h014: if (y < 8) r[24] = r[24] & ~(1 << y);
          10'h015: if (y < 8) r[24] = r[24] | (1 << y);
          10'h024: pend = 1;
          10'h28C: r[25] = 0;
          10'h28D: r[25] = 1;
          default: ;
        endcase
      end
    end
    #1;
    `CHK("acc write", n_we[0], resp_o.acc_we)
    `CHK("skip", n_skip[0], resp_o.skip)
    if (n_we) `CHK("acc value", n_acc[3:0], resp_o.acc)
    for (int i = 0; i < 24; i++) begin
      `CHK("register nibble", r[i][3:0], nibs[4*i +: 4])
    end
    `CHK("port d latch", r[24][7:0], port_d_o)
    `CHK("port c", r[25][0], port_c_o)
    `CHK("bus read", n_rd[7:0], bus_rdata_o)
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic drive(input logic [9:0] op, input logic vld);
    logic [31:0] v;
    v = rnd();
    @(posedge clk_i);
    core_i <= '{valid: vld, op: op, acc: v[3:0], y: v[7:4]};
    ext_lvl <= v[23:8];
    sink <= v[31:24];
  endtask

  task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    @(posedge clk_i);
    bus_i <= '{wr: wr, rd: !wr, addr: addr, wdata: wd};
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  initial begin
    #(4000 * 8);
    errors++;
    report_and_stop();
  end

  initial begin : main
    logic [31:0] v;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, then write and read back every place, plus two bad addresses
    for (int i = 0; i < 27; i++) bus(1'b0, 8'(i * 4), 8'h00);
    for (int i = 0; i < 27; i++) begin
      v = rnd();
      bus(1'b1, 8'(i * 4), v[7:0]);
      bus(1'b0, 8'(i * 4), 8'h00);
    end
    bus(1'b1, 8'h01, 8'hFF);
    bus(1'b0, 8'h01, 8'h00);
    @(posedge clk_i);
    bus_i <= '0;
    // Every opcode back to back, then a random program
    foreach (all_op[i]) drive(all_op[i], 1'b1);
    repeat (1500) begin
      v = rnd();
      drive(all_op[v[15:0] % 45], v[20]);
    end
    drive(10'h000, 1'b0);
    repeat (3) @(posedge clk_i);
    report_and_stop();
  end
endmodule
